//--- bench/nsc_ctrl_chk.sv
// Assertion checker for the store/recall host controller pins
`timescale 1ns/1ns
module nsc_ctrl_chk #(
    parameter ADDR_W = 17
) (
    input wire              i_clk, i_reset_n, i_store_busy_n,
    input wire              o_chip_sel_n, o_out_en_n, o_write_n, o_dq_oe,
    input wire              o_store_busy_n, o_store_busy_oe,
    input wire [ADDR_W-1:0] o_mem_addr
);
    // ----------------------------------------
    // Pin protocol
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    strobe_excl_a: assert property (!o_chip_sel_n |-> o_out_en_n || o_write_n)
        else $error("read and write strobes together");
    seq_we_high_a: assert property (!o_out_en_n |-> o_write_n)
        else $error("write strobe low during a read");
    busy_wait_a: assert property ($fell(o_chip_sel_n) |-> i_store_busy_n)
        else $error("access started while busy");
    strobe_len_a: assert property ($fell(o_chip_sel_n) |-> !o_chip_sel_n[*5] ##1 o_chip_sel_n)
        else $error("access strobe not five cycles");
    busy_low_a: assert property (o_store_busy_oe |-> !o_store_busy_n)
        else $error("busy line driven high by host");
    hw_pulse_a: assert property ($rose(o_store_busy_oe) |-> o_store_busy_oe[*6] ##1 !o_store_busy_oe)
        else $error("store request pulse not six cycles");
    dq_dir_a: assert property (o_dq_oe |-> o_out_en_n)
        else $error("data bus contention");
    addr_hold_a: assert property (!o_chip_sel_n && !$past(o_chip_sel_n) |-> $stable(o_mem_addr))
        else $error("address moved inside an access");
    host_off_a: assert property (o_store_busy_oe |-> o_chip_sel_n)
        else $error("access while requesting a store");
endmodule

//--- bench/nsc_ctrl_tb.sv
// Self-checking bench for the store/recall host controller
`timescale 1ns/1ns
module nsc_ctrl_tb;
    reg         i_clk = 0, i_reset_n = 0, i_ce = 1, i_wr = 0, i_rd = 0;
    reg  [3:0]  i_addr = 4'h0;
    reg  [31:0] i_wdata = 32'h0, v;
    reg  [15:0] flt = 16'h0;
    wire [31:0] o_rdata;
    wire [16:0] o_mem_addr;
    wire [15:0] o_dq, m_dq, i_dq;
    wire        o_chip_sel_n, o_out_en_n, o_write_n, o_upper_byte_select_n, o_dq_oe;
    wire        o_lower_byte_select_n, o_store_busy_n, o_store_busy_oe, m_dq_oe, m_boe, m_bval;
    wire        i_store_busy_n;
    int         n_errors = 0, num_checks = 0, s0;
    reg  [16:0] r_a [0:2] = '{17'h5, 17'h5, 17'h9};
    reg  [15:0] r_d [0:2] = '{16'h1234, 16'habcd, 16'h0f0f};
    reg  [15:0] r_e [0:2] = '{16'h1234, 16'h12cd, 16'h0f00};
    reg  [1:0]  r_b [0:2] = '{2'h0, 2'h2, 2'h1};
    // Pull-up: a released busy line reads high
    assign i_store_busy_n = !((o_store_busy_oe && !o_store_busy_n) || (m_boe && !m_bval));
    // An undriven bus shows a moving pattern so stale data cannot pass
    assign i_dq = m_dq_oe ? m_dq : (o_dq_oe ? o_dq : flt);
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) flt <= flt + 16'h1357;
    nsc_ctrl #(.STORE_CYC(200), .PU_RECALL_CYC(200)) dut_u (.i_clk, .i_reset_n, .i_ce, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_mem_addr, .o_chip_sel_n, .o_out_en_n, .o_write_n,
        .o_upper_byte_select_n, .o_lower_byte_select_n, .o_dq, .o_dq_oe, .i_dq, .i_store_busy_n,
        .o_store_busy_n, .o_store_busy_oe);
    nsc_mem_model mdl_u (.i_clk, .i_addr(o_mem_addr), .i_cs_n(o_chip_sel_n),
        .i_oe_n(o_out_en_n), .i_we_n(o_write_n), .i_ub_n(o_upper_byte_select_n),
        .i_lb_n(o_lower_byte_select_n), .i_busy_n(i_store_busy_n), .i_dq, .o_dq(m_dq),
        .o_dq_oe(m_dq_oe), .o_busy_oe(m_boe), .o_busy_val(m_bval));
    task chk(input [31:0] g, input [31:0] e);
        num_checks++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            n_errors++;
        end
    endtask
    task complete_run;
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task wait_idle;
        for (int k = 0; k < 2000; k++) begin
            rd(4'h4);
            if (v[0] === 1'b0) return;
        end
        n_errors++;
        complete_run;
    endtask
    task cmd(input [31:0] c);
        wr(4'h0, c);
        wait_idle;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        chk({o_chip_sel_n, o_write_n, o_out_en_n, o_dq_oe, o_store_busy_oe}, 5'h1c);
        i_reset_n <= 1'b1;
        wait_idle;
        for (int i = 0; i < 3; i++) begin
            wr(4'h1, {15'h0, r_a[i]});
            wr(4'h2, {16'h0, r_d[i]});
            cmd({26'h0, r_b[i], 4'h2});
            cmd(32'h1);
            rd(4'h3);
            chk(v & 32'hffff, {16'h0, r_e[i]});
        end
        s0 = mdl_u.n_store;
        cmd(32'h3);
        chk(mdl_u.n_store, s0 + 1);
        cmd(32'h7);
        chk(mdl_u.n_store, s0 + 1);
        cmd(32'h2);
        cmd(32'h7);
        chk(mdl_u.n_store, s0 + 2);
        wr(4'h2, 32'h5a5a);
        cmd(32'h2);
        cmd(32'h4);
        chk(mdl_u.n_recall, 1);
        cmd(32'h1);
        rd(4'h3);
        chk(v & 32'hffff, 32'h0f0f);
        cmd(32'h5);
        rd(4'h4);
        chk({mdl_u.auto_off, v[5]}, 2'h3);
        cmd(32'h6);
        rd(4'h4);
        chk({mdl_u.auto_off, v[5]}, 2'h0);
        rd(4'hf);
        chk(v, 32'h0);
        // Brown-out: auto save on the drop, recall on the rise
        cmd(32'h2);
        @(posedge i_clk);
        mdl_u.core_low <= 1'b1;
        repeat (300) @(posedge i_clk);
        chk(mdl_u.n_store, s0 + 3);
        mdl_u.core_low <= 1'b0;
        repeat (300) @(posedge i_clk);
        chk(mdl_u.n_recall, 2);
        cmd(32'h1);
        rd(4'h3);
        chk(v & 32'hffff, 32'h5a5a);
        complete_run;
    end
endmodule
bind nsc_ctrl nsc_ctrl_chk #(.ADDR_W(ADDR_W)) chk_u (.i_clk, .i_reset_n, .i_store_busy_n,
    .o_chip_sel_n, .o_out_en_n, .o_write_n, .o_dq_oe, .o_store_busy_n, .o_store_busy_oe,
    .o_mem_addr);

//--- bench/nsc_mem_model.sv
// Behavioural model of the store/recall memory for the controller bench
`timescale 1ns/1ns
`include "nsc_regs.vh"
module nsc_mem_model #(
    parameter ST = 150,
    parameter RC = 150,
    parameter HD = 3,
    parameter RV = 50
) (
    input  wire        i_clk,
    input  wire [16:0] i_addr,
    input  wire        i_cs_n, i_oe_n, i_we_n, i_ub_n, i_lb_n, i_busy_n,
    input  wire [15:0] i_dq,
    output wire [15:0] o_dq,
    output wire        o_dq_oe,
    output reg         o_busy_oe = 1'b1,
    output reg         o_busy_val = 1'b0
);
    reg [15:0] mem [0:255];
    reg [15:0] nv [0:255];
    reg [2:0]  idx = 3'h0;
    reg [1:0]  ph = 2'h1;
    reg        wrote = 1'b0, auto_off = 1'b0, prev_cs = 1'b1;
    int        cnt = RC, n_store = 0, n_recall = 0, rcv = RV;
    // Supply flags; the bench sets core_low to model brown-out events, io_low stays low
    reg        core_low = 1'b0, io_low = 1'b0, was_low = 1'b0, op_rc = 1'b1;
    function [12:0] f(input [16:0] x);
        f = x[14:2];
    endfunction
    function [16:0] seq_at(input [2:0] i);
        case (i)
            3'h0: seq_at = `NSC_SEQ_A0;
            3'h1: seq_at = `NSC_SEQ_A1;
            3'h2: seq_at = `NSC_SEQ_A2;
            3'h3: seq_at = `NSC_SEQ_A3;
            default: seq_at = `NSC_SEQ_A4;
        endcase
    endfunction
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0;
            nv[i] = 16'h0;
        end
    end
    // Off in recovery and at low I/O supply
    assign o_dq_oe = !i_cs_n && !i_oe_n && i_we_n && i_busy_n && rcv == 0 && !io_low;
    assign o_dq = mem[i_addr[7:0]];
    always @(posedge i_clk) begin
        prev_cs <= i_cs_n;
        was_low <= core_low;
        rcv <= !i_busy_n ? RV : (rcv > 0 ? rcv - 1 : 0);
        // Writes wait out recovery and low core supply
        if (!i_cs_n && !i_we_n && i_busy_n && rcv == 0 && !core_low) begin
            if (!i_ub_n) mem[i_addr[7:0]][15:8] <= i_dq[15:8];
            if (!i_lb_n) mem[i_addr[7:0]][7:0] <= i_dq[7:0];
            wrote <= 1'b1;
        end
        // Recall reuses the store timer: both hold the line low a fixed time
        if (ph == 2'h1) begin
            o_busy_oe <= 1'b1;
            o_busy_val <= 1'b0;
            cnt <= (cnt == 0) ? HD : cnt - 1;
            if (cnt == 0) ph <= 2'h2;
            if (cnt == 0 && op_rc) for (int i = 0; i < 256; i++) mem[i] <= nv[i];
            if (cnt == 0 && !op_rc) for (int i = 0; i < 256; i++) nv[i] <= mem[i];
        end else if (ph == 2'h2) begin
            o_busy_val <= 1'b1;
            cnt <= cnt - 1;
            if (cnt == 0) ph <= 2'h0;
            if (cnt == 0) o_busy_oe <= 1'b0;
        end else if (core_low && !was_low && !auto_off && wrote && !io_low) begin
            ph <= 2'h1;
            cnt <= ST;
            op_rc <= 1'b0;
            n_store++;
            wrote <= 1'b0;
        end else if (!core_low && was_low) begin
            ph <= 2'h1;
            cnt <= RC;
            op_rc <= 1'b1;
            n_recall++;
            wrote <= 1'b0;
        end else if (!i_busy_n && wrote && !core_low && !io_low) begin
            // Pin request honoured only after a write
            ph <= 2'h1;
            cnt <= ST;
            op_rc <= 1'b0;
            n_store++;
            wrote <= 1'b0;
        end
        if (prev_cs && !i_cs_n) begin
            if (!i_we_n) idx <= 3'h0;
            else if (idx == 3'h5) begin
                idx <= 3'h0;
                if (f(i_addr) == f(`NSC_SEQ_STORE) || f(i_addr) == f(`NSC_SEQ_RECALL)) begin
                    ph <= 2'h1;
                    cnt <= ST;
                    wrote <= 1'b0;
                    op_rc <= (f(i_addr) == f(`NSC_SEQ_RECALL));
                    if (f(i_addr) == f(`NSC_SEQ_STORE)) n_store++;
                    else n_recall++;
                end
                if (f(i_addr) == f(`NSC_SEQ_ASDIS)) auto_off <= 1'b1;
                if (f(i_addr) == f(`NSC_SEQ_ASEN)) auto_off <= 1'b0;
            end else if (f(i_addr) == f(seq_at(idx))) idx <= idx + 3'h1;
            else idx <= (f(i_addr) == f(`NSC_SEQ_A0)) ? 3'h1 : 3'h0;
        end
    end
endmodule

//--- verilog/nsc_ctrl.v
// Host controller driving the store/recall memory pins
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "nsc_regs.vh"
module nsc_ctrl #(
    parameter ADDR_W        = 17,
    parameter DATA_W        = 16,
    parameter STORE_CYC     = `NSC_STORE_NS / `NSC_CLK_NS,
    parameter PU_RECALL_CYC = `NSC_PU_RECALL_NS / `NSC_CLK_NS,
    parameter RECOVERY_CYC  = (`NSC_RECOVERY_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS
) (
    input  wire              i_clk,
    input  wire              i_reset_n,
    input  wire              i_ce,
    input  wire [3:0]        i_addr,
    input  wire [31:0]       i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output reg  [31:0]       o_rdata,
    output reg  [ADDR_W-1:0] o_mem_addr,
    output reg               o_chip_sel_n,
    output reg               o_out_en_n,
    output reg               o_write_n,
    output reg               o_upper_byte_select_n,
    output reg               o_lower_byte_select_n,
    output reg  [DATA_W-1:0] o_dq,
    output reg               o_dq_oe,
    input  wire [DATA_W-1:0] i_dq,
    input  wire              i_store_busy_n,
    output reg               o_store_busy_n,
    output reg               o_store_busy_oe
);
// ----------------------------------------
// Derived constants
// ----------------------------------------
localparam [7:0]  CYC_N   = (`NSC_CYC_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS;
localparam [31:0] TMO_N   = STORE_CYC + PU_RECALL_CYC + RECOVERY_CYC;
localparam [31:0] REC_N   = RECOVERY_CYC;
localparam [2:0]  S_IDLE  = 3'h0;
localparam [2:0]  S_SETUP = 3'h1;
localparam [2:0]  S_STRB  = 3'h2;
localparam [2:0]  S_GAP   = 3'h3;
localparam [2:0]  S_BUSY  = 3'h4;
localparam [2:0]  S_REC   = 3'h5;
localparam [2:0]  S_HOLD  = 3'h6;

// Sequence address for each step; last depends on command
function [ADDR_W-1:0] seq_addr;
    input [2:0] step;
    input [2:0] cmd;
    begin
        case (step)
            3'h0:    seq_addr = `NSC_SEQ_A0;
            3'h1:    seq_addr = `NSC_SEQ_A1;
            3'h2:    seq_addr = `NSC_SEQ_A2;
            3'h3:    seq_addr = `NSC_SEQ_A3;
            3'h4:    seq_addr = `NSC_SEQ_A4;
            default: begin
                case (cmd)
                    `NSC_CMD_SWSTORE:  seq_addr = `NSC_SEQ_STORE;
                    `NSC_CMD_SWRECALL: seq_addr = `NSC_SEQ_RECALL;
                    `NSC_CMD_ASDIS:    seq_addr = `NSC_SEQ_ASDIS;
                    default:           seq_addr = `NSC_SEQ_ASEN;
                endcase
            end
        endcase
    end
endfunction

reg  [2:0]        state_ff;
reg  [2:0]        cmd_ff;
reg  [2:0]        step_ff;
reg  [7:0]        cyc_ff;
reg  [31:0]       tmr_ff;
reg  [ADDR_W-1:0] addr_ff;
reg  [DATA_W-1:0] wdata_ff;
reg  [1:0]        bsel_n_ff;
reg  [DATA_W-1:0] rdata_ff;
reg               wrote_ff;
reg               timeout_ff;
reg               as_off_ff;

wire              busy_low = ~i_store_busy_n;
wire              is_seq   = (cmd_ff >= `NSC_CMD_SWSTORE) && (cmd_ff <= `NSC_CMD_ASEN);

// ----------------------------------------
// Register bus
// ----------------------------------------
always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_rdata <= 32'h0;
    end else if (i_ce) begin
        o_rdata <= 32'h0;
        if (i_rd) begin
            case (i_addr)
                `NSC_REG_ADDR:   o_rdata <= {{(32-ADDR_W){1'b0}}, addr_ff};
                `NSC_REG_WDATA:  o_rdata <= {{(32-DATA_W){1'b0}}, wdata_ff};
                `NSC_REG_RDATA:  o_rdata <= {{(32-DATA_W){1'b0}}, rdata_ff};
                `NSC_REG_STATUS: o_rdata <= {26'h0, as_off_ff, timeout_ff, wrote_ff,
                                             busy_low, i_store_busy_n, state_ff != S_IDLE};
                default:         o_rdata <= 32'h0;
            endcase
        end
    end
end

// ----------------------------------------
// Pin sequencer
// ----------------------------------------
always @(posedge i_clk) begin
    if (!i_reset_n) begin
        state_ff              <= S_REC;
        cmd_ff                <= 3'h0;
        step_ff               <= 3'h0;
        cyc_ff                <= 8'h0;
        tmr_ff                <= 32'h0;
        addr_ff               <= {ADDR_W{1'b0}};
        wdata_ff              <= {DATA_W{1'b0}};
        bsel_n_ff             <= 2'h0;
        rdata_ff              <= {DATA_W{1'b0}};
        wrote_ff              <= 1'b0;
        timeout_ff            <= 1'b0;
        as_off_ff             <= 1'b0;
        o_mem_addr            <= {ADDR_W{1'b0}};
        o_chip_sel_n          <= 1'b1;
        o_out_en_n            <= 1'b1;
        o_write_n             <= 1'b1;
        o_upper_byte_select_n <= 1'b1;
        o_lower_byte_select_n <= 1'b1;
        o_dq                  <= {DATA_W{1'b0}};
        o_dq_oe               <= 1'b0;
        o_store_busy_n        <= 1'b0;
        o_store_busy_oe       <= 1'b0;
    end else if (i_ce) begin
        if (i_wr && state_ff == S_IDLE) begin
            case (i_addr)
                `NSC_REG_ADDR:  addr_ff  <= i_wdata[ADDR_W-1:0];
                `NSC_REG_WDATA: wdata_ff <= i_wdata[DATA_W-1:0];
                `NSC_REG_CTRL: begin
                    cmd_ff     <= i_wdata[2:0];
                    bsel_n_ff  <= i_wdata[5:4];
                    step_ff    <= 3'h0;
                    timeout_ff <= 1'b0;
                    if (i_wdata[2:0] == `NSC_CMD_HWSTORE) begin
                        o_store_busy_oe <= 1'b1;
                        tmr_ff          <= 32'h0;
                        state_ff        <= S_HOLD;
                    end else if (i_wdata[2:0] != 3'h0) begin
                        state_ff <= S_SETUP;
                    end
                end
                default: ;
            endcase
        end
        case (state_ff)
            S_IDLE: ;
            S_SETUP: begin
                // Never start a cycle while the busy line is low
                if (!busy_low) begin
                    o_mem_addr   <= is_seq ? seq_addr(step_ff, cmd_ff) : addr_ff;
                    o_chip_sel_n <= 1'b0;
                    o_upper_byte_select_n <= is_seq ? 1'b0 : bsel_n_ff[1];
                    o_lower_byte_select_n <= is_seq ? 1'b0 : bsel_n_ff[0];
                    if (cmd_ff == `NSC_CMD_WRITE) begin
                        o_write_n <= 1'b0;
                        o_dq      <= wdata_ff;
                        o_dq_oe   <= 1'b1;
                    end else begin
                        o_write_n  <= 1'b1;
                        o_out_en_n <= 1'b0;
                    end
                    cyc_ff   <= 8'h0;
                    state_ff <= S_STRB;
                end
            end
            S_STRB: begin
                cyc_ff <= cyc_ff + 8'h1;
                if (cyc_ff == CYC_N - 8'h1) begin
                    rdata_ff     <= i_dq;
                    o_chip_sel_n <= 1'b1;
                    o_out_en_n   <= 1'b1;
                    o_write_n    <= 1'b1;
                    o_dq_oe      <= 1'b0;
                    o_upper_byte_select_n <= 1'b1;
                    o_lower_byte_select_n <= 1'b1;
                    if (cmd_ff == `NSC_CMD_WRITE)
                        wrote_ff <= 1'b1;
                    state_ff <= S_GAP;
                end
            end
            S_GAP: begin
                // Back to back reads only; nothing interleaves
                if (is_seq && step_ff != 3'h5) begin
                    step_ff  <= step_ff + 3'h1;
                    state_ff <= S_SETUP;
                end else if (cmd_ff == `NSC_CMD_SWSTORE || cmd_ff == `NSC_CMD_SWRECALL) begin
                    if (cmd_ff == `NSC_CMD_SWSTORE)
                        wrote_ff <= 1'b0;
                    tmr_ff   <= 32'h0;
                    state_ff <= S_BUSY;
                end else begin
                    if (cmd_ff == `NSC_CMD_ASDIS)
                        as_off_ff <= 1'b1;
                    if (cmd_ff == `NSC_CMD_ASEN)
                        as_off_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
            end
            S_HOLD: begin
                // Host owns the line for a fixed count; release it when tmr_ff reaches CYC_N
                tmr_ff <= tmr_ff + 32'h1;
                if (tmr_ff == CYC_N) begin
                    o_store_busy_oe <= 1'b0;
                    wrote_ff        <= 1'b0;
                    tmr_ff          <= 32'h0;
                    state_ff        <= S_BUSY;
                end
            end
            S_BUSY: begin
                // Wait for device busy to end, bounded
                tmr_ff <= tmr_ff + 32'h1;
                if (!busy_low) begin
                    tmr_ff   <= 32'h0;
                    state_ff <= S_REC;
                end else if (tmr_ff == TMO_N) begin
                    timeout_ff <= 1'b1;
                    state_ff   <= S_IDLE;
                end
            end
            S_REC: begin
                // Access resumes only after recovery
                tmr_ff <= tmr_ff + 32'h1;
                if (busy_low) begin
                    tmr_ff   <= 32'h0;
                    state_ff <= S_BUSY;
                end else if (tmr_ff >= REC_N) begin
                    tmr_ff   <= 32'h0;
                    state_ff <= S_IDLE;
                end
            end
            default: state_ff <= S_IDLE;
        endcase
    end
end

endmodule

//--- verilog/nsc_regs.vh
// Constants and register map of the store/recall host controller
// What this block does
// - Without writes, host must release busy line
// - Store sequence: six reads ending 0x8FC0
// - No access may interleave a sequence
// - Sequence reads keep write strobe high
// - Recall sequence ends with read 0x4C63
// - Auto save setting persists after a store
`ifndef NSC_REGS_VH
`define NSC_REGS_VH
// ----------------------------------------
// Host register offsets
// ----------------------------------------
`define NSC_REG_CTRL      4'h0
`define NSC_REG_ADDR      4'h1
`define NSC_REG_WDATA     4'h2
`define NSC_REG_RDATA     4'h3
`define NSC_REG_STATUS    4'h4
// ----------------------------------------
// Control register command codes
// ----------------------------------------
`define NSC_CMD_READ      3'h1
`define NSC_CMD_WRITE     3'h2
`define NSC_CMD_SWSTORE   3'h3
`define NSC_CMD_SWRECALL  3'h4
`define NSC_CMD_ASDIS     3'h5
`define NSC_CMD_ASEN      3'h6
`define NSC_CMD_HWSTORE   3'h7
// ----------------------------------------
// Command sequence addresses
// ----------------------------------------
`define NSC_SEQ_A0        17'h04e38
`define NSC_SEQ_A1        17'h0b1c7
`define NSC_SEQ_A2        17'h083e0
`define NSC_SEQ_A3        17'h07c1f
`define NSC_SEQ_A4        17'h0703f
`define NSC_SEQ_STORE     17'h08fc0
`define NSC_SEQ_RECALL    17'h04c63
`define NSC_SEQ_ASDIS     17'h08b45
`define NSC_SEQ_ASEN      17'h04b46
// ----------------------------------------
// Timing (ns) and clock
// ----------------------------------------
`define NSC_CLK_NS        10
`define NSC_CYC_NS        50
`define NSC_DELAY_NS      25
`define NSC_STORE_NS      8000000
`define NSC_PU_RECALL_NS  20000000
`define NSC_RECOVERY_NS   1000
`endif
